// ### utep_pkg.sv
`default_nettype none
package utep_pkg;
  // ---------------------------------------------------------------
  // Register map (word index; byte address is index times four)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_EP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TX_STAT = 8'h01;
  localparam logic [7:0] ADDR_TX_CMD = 8'h02;
  localparam logic [7:0] ADDR_TX_DATA = 8'h03;
  localparam logic [7:0] ADDR_FUNC_ADDR = 8'h04;
  localparam logic [7:0] ADDR_FRAME_LOW = 8'h13;
  localparam logic [7:0] ADDR_WARN_EV = 8'h05;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Endpoint control fields
  localparam int EPC_STALL = 7;
  localparam int EPC_ISO = 5;
  localparam int EPC_ACTIVE = 4;
  // Function address register fields
  localparam int FAR_EN = 7;
  // Transmit command fields
  localparam int TXC_BYPASS = 7;
  localparam int TXC_WARN_HI = 6;
  localparam int TXC_WARN_LO = 5;
  localparam int TXC_RFF = 4;
  localparam int TXC_FLUSH = 3;
  localparam int TXC_TOGGLE = 2;
  localparam int TXC_LAST = 1;
  localparam int TXC_EN = 0;

  // FIFO geometry
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam logic [6:0] FIFO_BYTES = 7'h40;
  localparam logic [6:0] COUNT_SAT = 7'h1F;
  localparam logic [6:0] WARN_4 = 7'h04;
  localparam logic [6:0] WARN_8 = 7'h08;
  localparam logic [6:0] WARN_16 = 7'h10;

  // Handshake answer codes toward the link
  typedef enum logic [1:0] {
    UTEP_HS_NONE,
    UTEP_HS_DATA,
    UTEP_HS_NAK,
    UTEP_HS_STALL
  } utep_hs_e;

  // Token from the serial engine
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [3:0] ep;
    logic is_in;
    logic is_out;
    logic is_setup;
  } utep_tok_s;

  // Outcome reported by the serial engine when an IN packet ends
  typedef struct packed {
    logic done;
    logic host_ack;
  } utep_end_s;
endpackage
`default_nettype wire

// ### utep_tx_pipe.sv
// Chosen here: register access over Avalon-MM and the register addresses.
`default_nettype none
module utep_tx_pipe (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire utep_pkg::utep_tok_s TOKEN,
  input wire logic SOF,
  input wire logic BYTE_REQ,
  input wire utep_pkg::utep_end_s PKT_END,
  output utep_pkg::utep_hs_e HANDSHAKE,
  output logic DATA1_PID,
  output logic [7:0] TX_BYTE,
  output logic TX_BYTE_VALID,
  output logic FORCE_STUFF_ERR,
  output logic SEND_LOW_WARNING
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_r, rst_n_r;
  // Two stages so reset deasserts cleanly on the core clock
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} utep_st_e;
  utep_st_e st_r;
  logic [7:0] epc_r, txc_r, far_r, fnl_r;
  logic done_r, ack_r, urun_r, warn_r, rd_pend_r;
  logic [7:0] mem_r [utep_pkg::FIFO_DEPTH];
  logic [utep_pkg::PTR_W-1:0] wp_r, rp_r, saved_rp_r;
  logic [6:0] used_r;
  logic [6:0] free_cnt;
  logic [4:0] free_byte_count;
  logic [7:0] stat_byte;
  logic acc_wr, acc_rd, tok_hit, in_hit, send_ok, frame_ok, busy;
  logic pop, push, iso, abort_now, warn_hit;

  // Word-wide decode shared by read and write paths
  function automatic logic sel(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // One wait state: accept on second cycle so read data is registered
  assign acc_wr = AVS_WRITE && rd_pend_r;
  assign acc_rd = AVS_READ && rd_pend_r;
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !rd_pend_r;
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) rd_pend_r <= 1'b0;
    else rd_pend_r <= (AVS_READ || AVS_WRITE) && !rd_pend_r;
  end

  assign iso = epc_r[utep_pkg::EPC_ISO];
  assign busy = (st_r != ST_IDLE);
  assign free_cnt = utep_pkg::FIFO_BYTES - used_r;
  // Saturating count, wider FIFO would overflow the 5-bit field
  assign free_byte_count = (free_cnt > utep_pkg::COUNT_SAT) ? 5'h1F
                  : free_cnt[4:0];
  assign stat_byte = {urun_r, ack_r, done_r, free_byte_count};

  // Token match: global enable, endpoint enable, address and number
  assign tok_hit = TOKEN.valid && far_r[utep_pkg::FAR_EN]
    && epc_r[utep_pkg::EPC_ACTIVE]
    && TOKEN.addr == far_r[6:0] && TOKEN.ep == epc_r[3:0];
  assign in_hit = tok_hit && TOKEN.is_in;
  assign frame_ok = txc_r[utep_pkg::TXC_BYPASS]
    || (fnl_r[0] == txc_r[utep_pkg::TXC_TOGGLE]);
  assign send_ok = txc_r[utep_pkg::TXC_EN] && (!iso || frame_ok);

  // Answer to a matched IN token, settled combinationally
  always_comb begin
    HANDSHAKE = utep_pkg::UTEP_HS_NONE;
    if (in_hit && st_r == ST_IDLE) begin
      if (epc_r[utep_pkg::EPC_STALL] && txc_r[utep_pkg::TXC_EN])
        HANDSHAKE = utep_pkg::UTEP_HS_STALL;
      else if (send_ok)
        HANDSHAKE = utep_pkg::UTEP_HS_DATA;
      else if (!iso)
        HANDSHAKE = utep_pkg::UTEP_HS_NAK;
    end
  end

  assign pop = (st_r == ST_SEND) && BYTE_REQ && used_r != 7'h00;
  assign push = acc_wr && sel(AVS_ADDRESS, utep_pkg::ADDR_TX_DATA)
                && AVS_BYTEENABLE[0];
  // Empty with no end mark while the engine wants bytes
  assign abort_now = (st_r == ST_SEND) && BYTE_REQ && used_r == 7'h00
                     && !txc_r[utep_pkg::TXC_LAST] && !push;

  // ---------------------------------------------------------------
  // Transmit state machine
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) st_r <= ST_IDLE;
    else begin
      case (st_r)
        ST_IDLE: if (HANDSHAKE == utep_pkg::UTEP_HS_DATA) st_r <= ST_SEND;
        ST_SEND: if (PKT_END.done) st_r <= ST_IDLE;
        ST_WAIT: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // PID choice; iso always DATA0, toggle never written by hardware
  assign DATA1_PID = !iso && txc_r[utep_pkg::TXC_TOGGLE];
  assign FORCE_STUFF_ERR = abort_now;

  // Byte out to the serial engine, registered
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      TX_BYTE <= utep_pkg::RESET_BYTE;
      TX_BYTE_VALID <= 1'b0;
    end else begin
      TX_BYTE_VALID <= pop;
      if (pop) TX_BYTE <= mem_r[rp_r];
    end
  end

  // ---------------------------------------------------------------
  // FIFO storage and pointers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (push && used_r != utep_pkg::FIFO_BYTES)
      mem_r[wp_r] <= AVS_WRITEDATA[7:0];
  end

  logic do_flush, do_refill, iso_drop;
  // Flush and refill wait out any packet in flight
  assign do_flush = txc_r[utep_pkg::TXC_FLUSH] && !busy;
  assign do_refill = txc_r[utep_pkg::TXC_RFF] && !busy;
  // Iso frame expired with data queued and no IN seen
  assign iso_drop = SOF && iso && txc_r[utep_pkg::TXC_EN] && frame_ok
                    && !busy;

  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wp_r <= '0;
      rp_r <= '0;
      used_r <= 7'h00;
    end else if (do_flush || iso_drop) begin
      wp_r <= '0;
      rp_r <= '0;
      used_r <= 7'h00;
    end else if (do_refill) begin
      rp_r <= saved_rp_r;
      used_r <= 7'(wp_r - saved_rp_r);
    end else begin
      if (push && used_r != utep_pkg::FIFO_BYTES) wp_r <= wp_r + 6'h01;
      if (pop) rp_r <= rp_r + 6'h01;
      if (push && used_r != utep_pkg::FIFO_BYTES && !pop)
        used_r <= used_r + 7'h01;
      else if (pop && !(push && used_r != utep_pkg::FIFO_BYTES))
        used_r <= used_r - 7'h01;
    end
  end

  // Read pointer snapshot taken when software marks the packet end
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) saved_rp_r <= '0;
    else if (acc_wr && sel(AVS_ADDRESS, utep_pkg::ADDR_TX_CMD)
             && AVS_WRITEDATA[utep_pkg::TXC_LAST])
      saved_rp_r <= rp_r;
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic cmd_wr;
  assign cmd_wr = acc_wr && sel(AVS_ADDRESS, utep_pkg::ADDR_TX_CMD)
                  && AVS_BYTEENABLE[0];
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      epc_r <= utep_pkg::RESET_BYTE;
      far_r <= utep_pkg::RESET_BYTE;
      fnl_r <= utep_pkg::RESET_BYTE;
    end else if (acc_wr && AVS_BYTEENABLE[0]) begin
      if (sel(AVS_ADDRESS, utep_pkg::ADDR_EP_CTRL))
        epc_r <= AVS_WRITEDATA[7:0] & 8'hBF;
      if (sel(AVS_ADDRESS, utep_pkg::ADDR_FUNC_ADDR))
        far_r <= AVS_WRITEDATA[7:0];
      if (sel(AVS_ADDRESS, utep_pkg::ADDR_FRAME_LOW))
        fnl_r <= AVS_WRITEDATA[7:0];
    end
  end

  // Command: hardware clears enable, last, flush, refill; write sets win
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) txc_r <= utep_pkg::RESET_BYTE;
    else if (cmd_wr) txc_r <= AVS_WRITEDATA[7:0];
    else begin
      if (PKT_END.done || HANDSHAKE == utep_pkg::UTEP_HS_STALL
          || iso_drop) begin
        txc_r[utep_pkg::TXC_EN] <= 1'b0;
        txc_r[utep_pkg::TXC_LAST] <= 1'b0;
      end
      if (do_flush) txc_r[utep_pkg::TXC_FLUSH] <= 1'b0;
      if (do_refill) txc_r[utep_pkg::TXC_RFF] <= 1'b0;
    end
  end

  // Status flags; a fresh event beats the read that clears them
  logic stat_rd;
  assign stat_rd = acc_rd && sel(AVS_ADDRESS, utep_pkg::ADDR_TX_STAT);
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      done_r <= 1'b0;
      ack_r <= 1'b0;
      urun_r <= 1'b0;
    end else begin
      if (PKT_END.done || HANDSHAKE == utep_pkg::UTEP_HS_STALL
          || iso_drop) begin
        done_r <= 1'b1;
        ack_r <= iso ? (PKT_END.done && !iso_drop)
                     : (PKT_END.done && PKT_END.host_ack);
      end else if (stat_rd) begin
        done_r <= 1'b0;
        ack_r <= 1'b0;
      end
      if (abort_now) urun_r <= 1'b1;
      else if (stat_rd) urun_r <= 1'b0;
    end
  end

  // Warning threshold decode
  always_comb begin
    case (txc_r[utep_pkg::TXC_WARN_HI:utep_pkg::TXC_WARN_LO])
      2'b01: warn_hit = used_r <= utep_pkg::WARN_4;
      2'b10: warn_hit = used_r <= utep_pkg::WARN_8;
      2'b11: warn_hit = used_r <= utep_pkg::WARN_16;
      default: warn_hit = 1'b0;
    endcase
  end
  // Gated by enable so filling before a send raises no warning
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) warn_r <= 1'b0;
    else if (warn_hit && txc_r[utep_pkg::TXC_EN]) warn_r <= 1'b1;
    else if (acc_rd && sel(AVS_ADDRESS, utep_pkg::ADDR_WARN_EV))
      warn_r <= 1'b0;
  end
  assign SEND_LOW_WARNING = warn_r;

  // Registered read data, unmapped reads as zero
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) AVS_READDATA <= 32'h0000_0000;
    else if (AVS_READ && !rd_pend_r) begin
      case (AVS_ADDRESS)
        utep_pkg::ADDR_EP_CTRL: AVS_READDATA <= {24'h0, epc_r};
        utep_pkg::ADDR_TX_STAT: AVS_READDATA <= {24'h0, stat_byte};
        utep_pkg::ADDR_TX_CMD: AVS_READDATA <= {24'h0, txc_r};
        utep_pkg::ADDR_FUNC_ADDR: AVS_READDATA <= {24'h0, far_r};
        utep_pkg::ADDR_FRAME_LOW: AVS_READDATA <= {24'h0, fnl_r};
        utep_pkg::ADDR_WARN_EV: AVS_READDATA <= {31'h0, warn_r};
        default: AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n_r);
  AST_NO_GLOBAL: assert property (!far_r[utep_pkg::FAR_EN] |->
    HANDSHAKE == utep_pkg::UTEP_HS_NONE) else $error("answer w/o enable");
  AST_ISO_NAK: assert property (iso |->
    HANDSHAKE != utep_pkg::UTEP_HS_NAK) else $error("iso NAK");
  AST_NO_SETUP_STALL: assert property (TOKEN.is_setup && !TOKEN.is_in
    |-> HANDSHAKE == utep_pkg::UTEP_HS_NONE) else $error("setup answered");
  // Above the saturation point the field must read exactly 31
  AST_COUNT_SAT: assert property (
    (utep_pkg::FIFO_BYTES - used_r > utep_pkg::COUNT_SAT)
    ? free_byte_count == 5'h1F
    : {2'b00, free_byte_count} == utep_pkg::FIFO_BYTES - used_r)
    else $error("count not sat");
  sequence stall_seq;
    HANDSHAKE == utep_pkg::UTEP_HS_STALL;
  endsequence
  AST_STALL_DONE: assert property (stall_seq |=> done_r
    && !txc_r[utep_pkg::TXC_EN] || $past(cmd_wr)) else $error("stall");
  AST_URUN: assert property (abort_now |=> urun_r)
    else $error("underrun lost");
  AST_ISO_PID: assert property (iso |-> !DATA1_PID)
    else $error("iso DATA1");
  AST_FLUSH: assert property (do_flush && !cmd_wr |=>
    used_r == 7'h00 && !txc_r[utep_pkg::TXC_FLUSH]) else $error("flush");
endmodule
`default_nettype wire

// ### utep_host_model.sv
`default_nettype none
// ---------------------------------------------------------------
// Host side of the link: tokens, byte pulls, end of packet
// ---------------------------------------------------------------
module utep_host_model (
  input wire logic core_clk,
  input wire utep_pkg::utep_hs_e handshake,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_valid,
  input wire logic force_stuff_err,
  output utep_pkg::utep_tok_s token,
  output logic sof,
  output logic byte_req,
  output utep_pkg::utep_end_s pkt_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  logic stuffed;

  // Quiet link at time zero
  initial begin
    token = '0;
    sof = 1'b0;
    byte_req = 1'b0;
    pkt_end = '0;
    stuffed = 1'b0;
  end

  // One token pulse; the answer is read mid-cycle once it has settled
  task automatic tok(input logic [6:0] a, input logic [3:0] e,
      input logic setup, output utep_pkg::utep_hs_e hs);
    @(posedge core_clk);
    token <= {1'b1, a, e, ~setup, 1'b0, setup};
    @(negedge core_clk);
    hs = handshake;
    @(posedge core_clk);
    token <= {1'b0, ~a, ~e, 3'b000}; // Stale fields inverted, not held
  endtask

  // One request per byte, so a missing byte cannot hide behind a level
  task automatic pull(input int n);
    stuffed = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      byte_req <= 1'b1;
      @(negedge core_clk);
      if (force_stuff_err === 1'b1) stuffed = 1'b1;
      @(posedge core_clk);
      byte_req <= 1'b0;
      @(negedge core_clk);
      if (tx_byte_valid === 1'b1) got.push_back(tx_byte);
    end
  endtask

  // Packet over, with or without the host handshake
  task automatic end_pkt(input logic ack);
    @(posedge core_clk);
    pkt_end <= {1'b1, ack};
    @(posedge core_clk);
    pkt_end <= '0;
  endtask

  // Start of frame pulse
  task automatic frame_start();
    @(posedge core_clk);
    sof <= 1'b1;
    @(posedge core_clk);
    sof <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### usb_tx_endpoint_pipe_bench.sv
`default_nettype none
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module usb_tx_endpoint_pipe_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic nrst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire utep_pkg::utep_tok_s token;
  wire logic sof;
  wire logic byte_req;
  wire utep_pkg::utep_end_s pkt_end;
  wire utep_pkg::utep_hs_e hs_w;
  wire logic data1_pid;
  wire logic [7:0] tx_byte;
  wire logic tx_byte_valid;
  wire logic stuff_err;
  wire logic low_warn;
  int miscompares = 0;
  int samples_checked = 0;
  utep_pkg::utep_hs_e hs;
  logic [7:0] q;

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  utep_tx_pipe u_utep_tx_pipe (.CORE_CLK(core_clk), .NRST(nrst),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .TOKEN(token), .SOF(sof),
    .BYTE_REQ(byte_req), .PKT_END(pkt_end), .HANDSHAKE(hs_w),
    .DATA1_PID(data1_pid), .TX_BYTE(tx_byte),
    .TX_BYTE_VALID(tx_byte_valid), .FORCE_STUFF_ERR(stuff_err),
    .SEND_LOW_WARNING(low_warn));

  utep_host_model u_host (.core_clk(core_clk), .handshake(hs_w),
    .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .force_stuff_err(stuff_err), .token(token), .sof(sof),
    .byte_req(byte_req), .pkt_end(pkt_end));

  // ---------------------------------------------------------------
  // Register bus master
  // ---------------------------------------------------------------
  // Request held until waitrequest is seen low; a stuck slave is
  // left to the watchdog, the only limit on a wait
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    `CHK(q, e)
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    @(posedge core_clk);
    // Bus idle while reset is held
    avs_address <= 8'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h00000000;
    avs_byteenable <= 4'h0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd_chk(utep_pkg::ADDR_EP_CTRL, 8'h00);
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h1F);
    rd_chk(utep_pkg::ADDR_TX_CMD, 8'h00);
    rd_chk(8'h7F, 8'h00);
    wr(utep_pkg::ADDR_EP_CTRL, 8'h13);
    wr(utep_pkg::ADDR_FUNC_ADDR, 8'h05);
    for (int i = 0; i < 36; i++) begin
      wr(utep_pkg::ADDR_TX_DATA, 8'hA0 + i[7:0]);
    end
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h1C);
    wr(utep_pkg::ADDR_TX_CMD, 8'h67);
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    `CHK(hs, utep_pkg::UTEP_HS_NONE)
    `CHK(data1_pid, 1'b1)
    wr(utep_pkg::ADDR_FUNC_ADDR, 8'h85);
    u_host.tok(7'h05, 4'h4, 1'b0, hs);
    `CHK(hs, utep_pkg::UTEP_HS_NONE)
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    `CHK(hs, utep_pkg::UTEP_HS_DATA)
    u_host.pull(36);
    u_host.end_pkt(1'b1);
    for (int i = 0; i < 36; i++) begin
      `CHK(u_host.got[i], 8'hA0 + i[7:0])
    end
    `CHK(low_warn, 1'b1)
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h7F);
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h1F);
    rd_chk(utep_pkg::ADDR_TX_CMD, 8'h64);
    rd_chk(utep_pkg::ADDR_WARN_EV, 8'h01);
    // Resend the same packet after the host lost it
    wr(utep_pkg::ADDR_TX_CMD, 8'h10);
    rd_chk(utep_pkg::ADDR_TX_CMD, 8'h00);
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h1C);
    wr(utep_pkg::ADDR_TX_CMD, 8'h03);
    u_host.got.delete();
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    u_host.pull(36);
    u_host.end_pkt(1'b0);
    `CHK(u_host.got[35], 8'hC3)
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h3F);
    // Stall answers IN but never SETUP
    wr(utep_pkg::ADDR_EP_CTRL, 8'h93);
    wr(utep_pkg::ADDR_TX_CMD, 8'h01);
    u_host.tok(7'h05, 4'h3, 1'b1, hs);
    `CHK(hs, utep_pkg::UTEP_HS_NONE)
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    `CHK(hs, utep_pkg::UTEP_HS_STALL)
    u_host.end_pkt(1'b0);
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h3F);
    rd_chk(utep_pkg::ADDR_TX_CMD, 8'h00);
    // Underrun: two bytes, no last mark, three pulled
    wr(utep_pkg::ADDR_EP_CTRL, 8'h13);
    wr(utep_pkg::ADDR_TX_DATA, 8'h11);
    wr(utep_pkg::ADDR_TX_DATA, 8'h22);
    wr(utep_pkg::ADDR_TX_CMD, 8'h01);
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    u_host.pull(3);
    u_host.end_pkt(1'b0);
    `CHK(u_host.stuffed, 1'b1)
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'hBF);
    // Flush while idle
    wr(utep_pkg::ADDR_TX_DATA, 8'h33);
    wr(utep_pkg::ADDR_TX_CMD, 8'h08);
    rd_chk(utep_pkg::ADDR_TX_CMD, 8'h00);
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h1F);
    // Data write without lane 0 must not reach the FIFO
    bus(1'b1, utep_pkg::ADDR_TX_DATA, 8'h44, 4'hE);
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h1F);
    // Isochronous: no NAK, frame lock, DATA0 only
    wr(utep_pkg::ADDR_EP_CTRL, 8'h33);
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    `CHK(hs == utep_pkg::UTEP_HS_NAK, 1'b0)
    wr(utep_pkg::ADDR_FRAME_LOW, 8'h00);
    wr(utep_pkg::ADDR_TX_DATA, 8'h55);
    wr(utep_pkg::ADDR_TX_CMD, 8'h07);
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    `CHK(hs == utep_pkg::UTEP_HS_DATA, 1'b0)
    wr(utep_pkg::ADDR_FRAME_LOW, 8'h01);
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    `CHK(hs, utep_pkg::UTEP_HS_DATA)
    `CHK(data1_pid, 1'b0)
    u_host.pull(1);
    u_host.end_pkt(1'b0);
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h7F);
    // Queued packet dropped at start of frame when no IN came
    wr(utep_pkg::ADDR_TX_DATA, 8'h66);
    wr(utep_pkg::ADDR_TX_CMD, 8'h07);
    u_host.frame_start();
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h3F);
    // Frame lock bypassed: sent on the next IN
    wr(utep_pkg::ADDR_FRAME_LOW, 8'h00);
    wr(utep_pkg::ADDR_TX_DATA, 8'h77);
    wr(utep_pkg::ADDR_TX_CMD, 8'h87);
    u_host.tok(7'h05, 4'h3, 1'b0, hs);
    `CHK(hs, utep_pkg::UTEP_HS_DATA)
    `CHK(data1_pid, 1'b0)
    u_host.pull(1);
    u_host.end_pkt(1'b0);
    `CHK(u_host.got[39], 8'h77)
    rd_chk(utep_pkg::ADDR_TX_STAT, 8'h7F);
    give_verdict();
  end
endmodule
`default_nettype wire
